// ===== hw/dwru_pkg.sv
/*
  Constants for the dual watchdog reset unit: clock rate, time bases
  and the derived cycle and tick counts.
  Assumes a 20 MHz core clock and a 128 kHz low speed oscillator tick.
*/
package dwru_pkg;

  // ****************************************
  // Clock rates
  // ****************************************
  localparam int unsigned CORE_CLK_PERIOD_NS    = 50;
  localparam int unsigned LOW_SPEED_OSC_FREQ_HZ = 128000;

  // ****************************************
  // Window watchdog time base
  // ****************************************
  localparam int unsigned WW_STEP_NS   = 75000;
  localparam int unsigned WW_MAX_MS    = 64;
  localparam int unsigned WW_STEP_CYC  =
    (WW_STEP_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
  localparam int unsigned WW_MAX_STEPS = (WW_MAX_MS * 1000000) / WW_STEP_NS;

  // ****************************************
  // Independent watchdog time base
  // ****************************************
  localparam int unsigned IW_MIN_US    = 60;
  localparam int unsigned IW_MAX_S     = 1;
  localparam int unsigned IW_MIN_TICKS =
    (IW_MIN_US * LOW_SPEED_OSC_FREQ_HZ + 999999) / 1000000;
  localparam int unsigned IW_MAX_TICKS = IW_MAX_S * LOW_SPEED_OSC_FREQ_HZ;

endpackage

// ===== hw/dwru_top.sv
/*
  Dual watchdog reset unit: a window watchdog stepped from the core clock
  and an independent watchdog stepped by the low speed oscillator tick.
  Assumes all inputs are synchronous to core_clk and that the reset
  request, once raised, leads the system to assert resetn.
*/
`timescale 1ns/1ns

module dwru_top
  import dwru_pkg::*;
#(
  parameter int unsigned WW_W = 10,
  parameter int unsigned IW_W = 17
) (
  // Clock and reset
  input  wire logic            core_clk,
  input  wire logic            resetn,
  // Activation
  input  wire logic            ww_opt_en,
  input  wire logic            iw_opt_en,
  input  wire logic            ww_sw_en,
  input  wire logic            iw_sw_en,
  // Window watchdog control
  input  wire logic            ww_refresh,
  input  wire logic [WW_W-1:0] ww_load,
  input  wire logic [WW_W-1:0] ww_window,
  // Independent watchdog control
  input  wire logic            low_speed_internal_osc_tick,
  input  wire logic            iw_refresh,
  input  wire logic [IW_W-1:0] iw_reload,
  // Status and reset request
  output logic                 ww_active,
  output logic                 iw_active,
  output logic                 ww_cause,
  output logic                 iw_cause,
  output logic                 dev_reset_req
);

  // ****************************************
  // Parameter check
  // ****************************************
  if (WW_W > 31 || IW_W > 31 ||
      WW_MAX_STEPS >= (1 << WW_W) || IW_MAX_TICKS >= (1 << IW_W)) begin : g_bad_width
    $error("dwru_top: counter widths unsupported");
  end

  localparam int unsigned PW = $clog2(WW_STEP_CYC + 1);
  localparam logic [PW-1:0]   PRE_LAST = PW'(WW_STEP_CYC - 1);
  localparam logic [WW_W-1:0] WW_MAX   = WW_W'(WW_MAX_STEPS);
  localparam logic [WW_W-1:0] WW_ONE   = WW_W'(1);
  localparam logic [IW_W-1:0] IW_MIN   = IW_W'(IW_MIN_TICKS);
  localparam logic [IW_W-1:0] IW_MAX   = IW_W'(IW_MAX_TICKS);
  localparam logic [IW_W-1:0] IW_ONE   = IW_W'(1);

  typedef struct packed {
    logic            started;
    logic            ww_act;
    logic            iw_act;
    logic [PW-1:0]   pre;
    logic [WW_W-1:0] ww_cnt;
    logic [IW_W-1:0] iw_cnt;
    logic            ww_cause;
    logic            iw_cause;
    logic            rst;
  } dwru_state_t;

  dwru_state_t st_q;
  dwru_state_t st_d;

  logic [WW_W-1:0] ww_start;
  logic [IW_W-1:0] iw_start;
  logic            ww_step;

  // ****************************************
  // Start values clamped to the legal range
  // ****************************************
  assign ww_start = (ww_load == '0) ? WW_ONE : ((ww_load > WW_MAX) ? WW_MAX : ww_load);
  assign iw_start = (iw_reload < IW_MIN) ? IW_MIN :
                    ((iw_reload > IW_MAX) ? IW_MAX : iw_reload);
  assign ww_step  = (st_q.pre == PRE_LAST);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_d = st_q;
    if (!st_q.started) begin
      st_d.started = 1'h1;
      st_d.ww_act  = ww_opt_en;
      st_d.iw_act  = iw_opt_en;
      st_d.ww_cnt  = ww_start;
      st_d.iw_cnt  = iw_start;
    end else if (!st_q.rst) begin
      if (ww_sw_en && !st_q.ww_act) begin
        st_d.ww_act = 1'h1;
        st_d.ww_cnt = ww_start;
        st_d.pre    = '0;
      end
      if (iw_sw_en && !st_q.iw_act) begin
        st_d.iw_act = 1'h1;
        st_d.iw_cnt = iw_start;
      end
      // Window watchdog time base
      if (st_q.ww_act) begin
        st_d.pre = ww_step ? '0 : st_q.pre + PW'(1);
        if (ww_refresh) begin
          if (st_q.ww_cnt > ww_window) begin
            st_d.rst      = 1'h1;
            st_d.ww_cause = 1'h1;
          end else begin
            st_d.ww_cnt = ww_start;
            st_d.pre    = '0;
          end
        end else if (ww_step) begin
          if (st_q.ww_cnt == WW_ONE) begin
            st_d.rst      = 1'h1;
            st_d.ww_cause = 1'h1;
          end
          st_d.ww_cnt = st_q.ww_cnt - WW_ONE;
        end
      end
      if (st_q.iw_act) begin
        if (iw_refresh) begin
          st_d.iw_cnt = iw_start;
        end else if (low_speed_internal_osc_tick) begin
          if (st_q.iw_cnt == IW_ONE) begin
            st_d.rst      = 1'h1;
            st_d.iw_cause = 1'h1;
          end
          st_d.iw_cnt = st_q.iw_cnt - IW_ONE;
        end
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign ww_active     = st_q.ww_act;
  assign iw_active     = st_q.iw_act;
  assign ww_cause      = st_q.ww_cause;
  assign iw_cause      = st_q.iw_cause;
  assign dev_reset_req = st_q.rst;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_ww_early;
    st_q.started && st_q.ww_act && !st_q.rst && ww_refresh && (st_q.ww_cnt > ww_window);
  endsequence

  sequence s_ww_valid;
    st_q.started && st_q.ww_act && !st_q.rst && ww_refresh && (st_q.ww_cnt <= ww_window);
  endsequence

  sequence s_ww_expire;
    st_q.started && st_q.ww_act && !st_q.rst && !ww_refresh && ww_step
      && (st_q.ww_cnt == WW_ONE);
  endsequence

  sequence s_iw_expire;
    st_q.started && st_q.iw_act && !st_q.rst && low_speed_internal_osc_tick && !iw_refresh
      && (st_q.iw_cnt == IW_ONE);
  endsequence

  a_reset_holds: assert property (dev_reset_req |=> dev_reset_req)
    else $error("reset request dropped before reset");
  a_option_enable: assert property (!st_q.started ##1 st_q.started |->
      (ww_active == $past(ww_opt_en, 1)) && (iw_active == $past(iw_opt_en, 1)))
    else $error("option setting not applied");
  a_sw_enable: assert property (st_q.started && !st_q.rst && ww_sw_en |=> ww_active)
    else $error("software enable ignored");
  a_iw_sw_enable: assert property (st_q.started && !st_q.rst && iw_sw_en |=> iw_active)
    else $error("independent software enable ignored");
  a_ww_stays_on: assert property (ww_active |=> ww_active)
    else $error("window watchdog disabled");
  a_iw_stays_on: assert property (iw_active |=> iw_active)
    else $error("independent watchdog disabled");
  a_ww_timeout: assert property (s_ww_expire |=> dev_reset_req && ww_cause)
    else $error("window expiry gave no reset");
  a_ww_early: assert property (s_ww_early |=> dev_reset_req && ww_cause)
    else $error("early refresh gave no reset");
  a_iw_counts: assert property (st_q.started && iw_active && !st_q.rst
      && low_speed_internal_osc_tick && !iw_refresh && st_q.iw_cnt > IW_ONE |=>
      st_q.iw_cnt == $past(st_q.iw_cnt) - IW_ONE && !iw_cause)
    else $error("independent counter not stepped");
  a_iw_timeout: assert property (s_iw_expire |=> dev_reset_req && iw_cause)
    else $error("independent expiry gave no reset");
  a_iw_reload: assert property (st_q.started && iw_active && !st_q.rst && iw_refresh |=>
      st_q.iw_cnt == $past(iw_start) && !iw_cause)
    else $error("independent refresh did not reload");
  a_ww_reload: assert property (s_ww_valid |=>
      st_q.ww_cnt == $past(ww_start) && !ww_cause ##1
      (st_q.ww_cnt == $past(st_q.ww_cnt) || st_q.ww_cnt == $past(st_q.ww_cnt) - WW_ONE))
    else $error("window refresh did not reload");

endmodule

// ===== testbench/dwru_top_test.sv
/*
  Self-checking bench for dwru_top: activation, window timeout and early
  refresh, independent watchdog ticks, reload and expiry.
  Assumes a 20 MHz core clock and the design's default widths.
*/
`timescale 1ns/1ns
module dwru_top_test;
  import dwru_pkg::*;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic        core_clk, resetn, ww_opt_en, iw_opt_en, ww_sw_en, iw_sw_en;
  logic        ww_refresh, low_speed_internal_osc_tick, iw_refresh;
  logic [9:0]  ww_load, ww_window;
  logic [16:0] iw_reload;
  logic        ww_active, iw_active, ww_cause, iw_cause, dev_reset_req;
  int          mismatches, samples_checked, cyc;
  dwru_top u_dwru_top (.core_clk(core_clk), .resetn(resetn), .ww_opt_en(ww_opt_en),
    .iw_opt_en(iw_opt_en), .ww_sw_en(ww_sw_en), .iw_sw_en(iw_sw_en),
    .ww_refresh(ww_refresh), .ww_load(ww_load), .ww_window(ww_window),
    .low_speed_internal_osc_tick(low_speed_internal_osc_tick), .iw_refresh(iw_refresh),
    .iw_reload(iw_reload),
    .ww_active(ww_active), .iw_active(iw_active), .ww_cause(ww_cause),
    .iw_cause(iw_cause), .dev_reset_req(dev_reset_req));
  // ****************************************
  // Clock, timeout and helpers
  // ****************************************
  initial begin
    core_clk = 1'h0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      stop_test();
    end
  end
  task automatic chk(input logic [4:0] seen, input logic [4:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [4:0] outs();
    return {ww_active, iw_active, ww_cause, iw_cause, dev_reset_req};
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #5;
  endtask
  task automatic rst(input logic ow, input logic oi);
    step(1);
    resetn = 1'h0;
    ww_opt_en = ow;
    iw_opt_en = oi;
    step(2);
    chk(outs(), 5'h00);  // reset clears all
    resetn = 1'h1;
    step(2);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      low_speed_internal_osc_tick = 1'h1;
      step(1);
      low_speed_internal_osc_tick = 1'h0;
      step(2);
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_options();
    rst(1'h1, 1'h1);
    chk(outs(), 5'h18);  // option enables both
    ww_load = 10'h3FF;
    step(20);
    chk(outs(), 5'h18);  // stays active
  endtask
  task automatic t_timeout();
    rst(1'h0, 1'h0);
    ww_load = 10'h001;
    ww_sw_en = 1'h1;
    step(1);
    ww_sw_en = 1'h0;
    chk(outs(), 5'h10);  // software enable
    step(WW_STEP_CYC - 1);
    chk(outs(), 5'h10);  // no early expiry
    step(1);
    chk(outs(), 5'h15);  // expiry after one step
  endtask
  task automatic t_early();
    ww_load = 10'h005;
    ww_window = 10'h002;
    rst(1'h1, 1'h0);
    ww_refresh = 1'h1;
    step(1);
    ww_refresh = 1'h0;
    chk(outs(), 5'h15);  // refresh above window resets
    step(1);
    chk(outs(), 5'h15);  // request and cause held
  endtask
  task automatic t_refresh();
    ww_load = 10'h002;
    ww_window = 10'h002;
    rst(1'h1, 1'h0);
    repeat (3) begin
      step(1000);
      ww_refresh = 1'h1;
      step(1);
      ww_refresh = 1'h0;
    end
    step(100);
    chk(outs(), 5'h10);  // in-window refresh reloads
    step(2 * WW_STEP_CYC - 101);
    chk(outs(), 5'h10);  // counting resumes from reload
    step(1);
    chk(outs(), 5'h15);  // expiry two steps after reload
  endtask
  task automatic t_indep();
    rst(1'h0, 1'h0);
    iw_reload = 17'h00000;
    ticks(8);
    chk(outs(), 5'h00);  // ticks ignored while inactive
    iw_sw_en = 1'h1;
    step(1);
    iw_sw_en = 1'h0;
    ticks(7);
    chk(outs(), 5'h08);  // minimum count not reached
    iw_refresh = 1'h1;
    step(1);
    iw_refresh = 1'h0;
    ticks(7);
    chk(outs(), 5'h08);  // refresh reloaded counter
    ticks(1);
    chk(outs(), 5'h0B);  // expiry resets device
  endtask
  task automatic stop_test();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    {resetn, ww_opt_en, iw_opt_en, ww_sw_en, iw_sw_en} = 5'h00;
    {ww_refresh, low_speed_internal_osc_tick, iw_refresh} = 3'h0;
    ww_load = 10'h001;
    ww_window = 10'h3FF;
    iw_reload = 17'h00008;
    mismatches = 0;
    samples_checked = 0;
    cyc = 0;
    t_options();
    t_timeout();
    t_early();
    t_refresh();
    t_indep();
    stop_test();
  end
endmodule
